//--- pkg/pmb_map.vh
/*
 * register offsets, field positions, reset values and bus codes for the
 * message box and bus lock block.
 * assumes it is included by bare name from the design files.
 */
`ifndef PMB_MAP_VH
`define PMB_MAP_VH

// controller register space, byte offsets on the cpu side
`define PMB_OFF_MSG_ONE     8'h30
`define PMB_OFF_MSG_TWO     8'h34
`define PMB_OFF_LOCK_CS     8'h60

// bus_lock_control_status fields
`define PMB_LCS_REQ         0
`define PMB_LCS_TGT_OFF     1
`define PMB_LCS_RETRY_HIT   2
`define PMB_LCS_ABORT       3
`define PMB_LCS_RESET       4'h0

// reset value of both message words
`define PMB_MSG_RESET       32'h0000_0000

// pci memory map: box two sits this far above box one
`define PMB_MSG_TWO_OFS     32'h0000_0800
`define PMB_WIN_HI          31
`define PMB_WIN_LO          12
`define PMB_WIN_SEL         11

// pci bus commands that reach the message words
`define PMB_CMD_MEM_RD      4'h6
`define PMB_CMD_MEM_WR      4'h7
`define PMB_CMD_MEM_RDM     4'hc
`define PMB_CMD_MEM_RDL     4'he
`define PMB_CMD_MEM_WRI     4'hf

`endif

//--- hw/pmb_mbox_mem.v
/*
 * two-word store for the message boxes, one port, registered read data.
 * assumes at most one access per cycle, arbitrated by the caller.
 */
`include "pmb_map.vh"

module pmb_mbox_mem (
   // clock and reset
   input  wire        i_clk,
   input  wire        i_nrst,
   // access port
   input  wire        i_en,
   input  wire        i_wr,
   input  wire        i_sel,
   input  wire [31:0] i_wdata,
   // read data, valid the cycle after i_en
   output reg  [31:0] o_rdata
);

   reg [31:0] word_one_reg;
   reg [31:0] word_two_reg;

   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         word_one_reg <= `PMB_MSG_RESET; // [R4]
         word_two_reg <= `PMB_MSG_RESET; // [R4]
         o_rdata      <= 32'h0000_0000;
      end else if (i_en) begin
         if (i_wr && !i_sel)
            word_one_reg <= i_wdata; // [R1]
         if (i_wr && i_sel)
            word_two_reg <= i_wdata; // [R1]
         // read returns the value before this write
         o_rdata <= i_sel ? word_two_reg : word_one_reg; // [R1]
      end
   end

endmodule // pmb_mbox_mem

//--- hw/pmb_top.v
/*
 * message box pair and pci exclusive-access logic: cpu register port,
 * pci target port for the boxes, master lock control and target lock.
 * assumes the pci core runs on i_clk and hands over decoded cycles as
 * one-cycle pulses; frame and lock pins arrive asynchronously.
 */
// How it works
// R1: two one-word message boxes, read and written by cpu and pci masters.
// R2: cpu sees box one at offset 30 and box two at offset 34.
// R3: pci claims boxes only on memory cycles at base; io and config ignored.
// R4: reset clears both message boxes to zero.
// R5: boxes answer pci once memory space enable is set; no other enable.
// R6: unprogrammed base puts boxes at 0x0 and 0x800; software sets base first.
// R7: any pci read or write of a box sets that box's interrupt flag.
// R8: cpu read or write of a box clears its interrupt flag.
// R9: lock request bit makes the next master access locked, lock pin driven.
// R10: clearing request releases lock after the in-progress access completes.
// R11: while holding a target locked, master talks only to that target.
// R12: locked retries reissued; reaching retry limit sets status bit 2.
// R13: master or target abort while driving lock sets status bit 3.
// R14: bit 1 zero accepts locked target cycles; one disables target locking.
// R15: target-locked state refuses other pci and cpu accesses until idle.
// R16: dram refresh keeps running while target locked.
// R17: lock control register at 0x60, bits 31:4 read zero.
// R18: retry-limit and abort bits stay set until written zero or reset.
`include "pmb_map.vh"

module pmb_top (
   // clock and reset
   input  wire        i_clk,
   input  wire        i_nrst,
   // cpu register port
   input  wire        i_cpu_req,
   input  wire        i_cpu_wr,
   input  wire [7:0]  i_cpu_addr,
   input  wire [31:0] i_cpu_wdata,
   output reg         o_cpu_ack,
   output reg         o_cpu_retry,
   output reg  [31:0] o_cpu_rdata,
   // pci configuration state
   input  wire        i_mem_space_enable_bit,
   input  wire [31:0] i_mbox_base,
   // pci target cycles
   input  wire        i_tgt_req,
   input  wire [3:0]  i_tgt_cmd,
   input  wire [31:0] i_tgt_addr,
   input  wire [31:0] i_tgt_wdata,
   input  wire        i_tgt_locked,
   input  wire        i_tgt_lock_owner,
   output reg         o_tgt_ack,
   output reg         o_tgt_retry,
   output reg  [31:0] o_tgt_rdata,
   output reg         o_tgt_lock_state,
   // pci pins
   input  wire        i_frame_n,
   input  wire        i_lock_n,
   output reg         o_lock_n,
   output reg         o_lock_n_oe,
   // pci master engine
   input  wire        i_mst_start,
   input  wire [31:0] i_mst_addr,
   input  wire        i_mst_done,
   input  wire        i_mst_retry,
   input  wire        i_mst_abort,
   input  wire [7:0]  i_retry_limit,
   output reg         o_mst_use_lock,
   output reg         o_mst_permit,
   output reg         o_mst_reissue,
   // interrupt flags and refresh
   output reg         o_msg_one_irq_flag,
   output reg         o_msg_two_irq_flag,
   input  wire        i_refresh_req,
   output reg         o_refresh_grant
);

   localparam M_IDLE   = 1'b0;
   localparam M_LOCK   = 1'b1;
   localparam T_IDLE   = 1'b0;
   localparam T_LOCKED = 1'b1;

   function is_mem_cmd;
      input [3:0] cmd;
      begin
         is_mem_cmd = (cmd == `PMB_CMD_MEM_RD)  ||
                      (cmd == `PMB_CMD_MEM_WR)  ||
                      (cmd == `PMB_CMD_MEM_RDM) ||
                      (cmd == `PMB_CMD_MEM_RDL) ||
                      (cmd == `PMB_CMD_MEM_WRI);
      end
   endfunction

   function is_wr_cmd;
      input [3:0] cmd;
      begin
         is_wr_cmd = (cmd == `PMB_CMD_MEM_WR) || (cmd == `PMB_CMD_MEM_WRI);
      end
   endfunction

   // pin synchronisers
   reg        frame_n_s1_reg;
   reg        frame_n_reg;
   reg        lock_n_s1_reg;
   reg        lock_n_reg;

   // control state
   reg        m_state_reg;
   reg        m_state_next;
   reg        t_state_reg;
   reg        t_state_next;
   reg [31:0] lock_tgt_reg;
   reg [7:0]  retry_cnt_reg;
   reg        lock_req_reg;
   reg        tgt_off_reg;
   reg        retry_hit_reg;
   reg        abort_reg;

   // pipeline of a box or lock register read
   reg        cpu_p1_reg;
   reg        cpu_box_p1_reg;
   reg [31:0] cpu_lcs_p1_reg;
   reg        tgt_p1_reg;

   // decode
   wire       cpu_one = i_cpu_addr == `PMB_OFF_MSG_ONE;
   wire       cpu_two = i_cpu_addr == `PMB_OFF_MSG_TWO;
   wire       cpu_lcs = i_cpu_addr == `PMB_OFF_LOCK_CS;
   wire       cpu_hit = i_cpu_req && (cpu_one || cpu_two || cpu_lcs); // [R2]
   wire       tgt_win = i_tgt_addr[`PMB_WIN_HI:`PMB_WIN_LO] ==
                        i_mbox_base[`PMB_WIN_HI:`PMB_WIN_LO]; // [R6]
   wire       tgt_sel = i_tgt_addr[`PMB_WIN_SEL]; // [R6]
   wire       tgt_hit = i_tgt_req && i_mem_space_enable_bit && // [R5]
                        is_mem_cmd(i_tgt_cmd) && tgt_win;      // [R3]
   wire       tgt_lock_in = tgt_hit && i_tgt_locked && !tgt_off_reg; // [R14]
   wire       t_locked = t_state_reg == T_LOCKED;
   // while target locked only the locking master's cycles get through
   wire       tgt_go = tgt_hit && (!t_locked || i_tgt_lock_owner); // [R15]
   wire       tgt_ref = tgt_hit && !tgt_go; // [R15]
   // a box access in the same cycle as pci goes to pci; cpu retries
   wire       cpu_box = cpu_hit && (cpu_one || cpu_two);
   wire       cpu_ref = cpu_hit && (t_locked || (cpu_box && tgt_go)); // [R15]
   wire       cpu_go = cpu_hit && !cpu_ref;
   wire       cpu_box_go = cpu_go && (cpu_one || cpu_two);
   wire       cpu_lcs_wr = cpu_go && cpu_lcs && i_cpu_wr;

   wire        mem_en = tgt_go || cpu_box_go;
   wire        mem_wr = tgt_go ? is_wr_cmd(i_tgt_cmd) : i_cpu_wr;
   wire        mem_sel = tgt_go ? tgt_sel : cpu_two;
   wire [31:0] mem_wdata = tgt_go ? i_tgt_wdata : i_cpu_wdata;
   wire [31:0] mem_rdata;

   wire [31:0] lcs_view = {28'h0000000, abort_reg, retry_hit_reg,
                           tgt_off_reg, lock_req_reg}; // [R17]

   pmb_mbox_mem u_mem (
      .i_clk   (i_clk),
      .i_nrst  (i_nrst),
      .i_en    (mem_en),
      .i_wr    (mem_wr),
      .i_sel   (mem_sel),
      .i_wdata (mem_wdata),
      .o_rdata (mem_rdata)
   );

   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         frame_n_s1_reg <= 1'b1;
         frame_n_reg    <= 1'b1;
         lock_n_s1_reg  <= 1'b1;
         lock_n_reg     <= 1'b1;
      end else begin
         frame_n_s1_reg <= i_frame_n;
         frame_n_reg    <= frame_n_s1_reg;
         lock_n_s1_reg  <= i_lock_n;
         lock_n_reg     <= lock_n_s1_reg;
      end
   end

   // master lock state
   always @* begin
      m_state_next = m_state_reg;
      case (m_state_reg)
         M_IDLE:
            if (i_mst_start && lock_req_reg && lock_n_reg)
               m_state_next = M_LOCK; // [R9]
         M_LOCK:
            // release only once the access in flight has finished
            if ((i_mst_done && !lock_req_reg) || i_mst_abort)
               m_state_next = M_IDLE; // [R10]
         default:
            m_state_next = M_IDLE;
      endcase
   end

   // target lock state
   always @* begin
      t_state_next = t_state_reg;
      case (t_state_reg)
         T_IDLE:
            if (tgt_lock_in)
               t_state_next = T_LOCKED; // [R15]
         T_LOCKED:
            if (frame_n_reg && lock_n_reg && !tgt_hit)
               t_state_next = T_IDLE; // [R15]
         default:
            t_state_next = T_IDLE;
      endcase
   end

   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         m_state_reg   <= M_IDLE;
         t_state_reg   <= T_IDLE;
         lock_tgt_reg  <= 32'h0000_0000;
         retry_cnt_reg <= 8'h00;
         lock_req_reg  <= 1'b0;
         tgt_off_reg   <= 1'b0;
         retry_hit_reg <= 1'b0;
         abort_reg     <= 1'b0;
      end else begin
         m_state_reg <= m_state_next;
         t_state_reg <= t_state_next;
         if (m_state_reg == M_IDLE && m_state_next == M_LOCK)
            lock_tgt_reg <= i_mst_addr; // [R11]
         if (m_state_reg == M_IDLE || i_mst_done)
            retry_cnt_reg <= 8'h00;
         else if (i_mst_retry && retry_cnt_reg != 8'hff)
            retry_cnt_reg <= retry_cnt_reg + 8'h01; // [R12]
         if (cpu_lcs_wr) begin
            lock_req_reg <= i_cpu_wdata[`PMB_LCS_REQ]; // [R9]
            tgt_off_reg  <= i_cpu_wdata[`PMB_LCS_TGT_OFF]; // [R14]
         end
         // set beats a software clear in the same cycle
         if (m_state_reg == M_LOCK && i_mst_retry &&
             retry_cnt_reg + 8'h01 >= i_retry_limit)
            retry_hit_reg <= 1'b1; // [R12]
         else if (cpu_lcs_wr && !i_cpu_wdata[`PMB_LCS_RETRY_HIT])
            retry_hit_reg <= 1'b0; // [R18]
         if (m_state_reg == M_LOCK && i_mst_abort)
            abort_reg <= 1'b1; // [R13]
         else if (cpu_lcs_wr && !i_cpu_wdata[`PMB_LCS_ABORT])
            abort_reg <= 1'b0; // [R18]
      end
   end

   // message interrupt flags, pci set wins over cpu clear
   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_msg_one_irq_flag <= 1'b0;
         o_msg_two_irq_flag <= 1'b0;
      end else begin
         if (tgt_go && !tgt_sel)
            o_msg_one_irq_flag <= 1'b1; // [R7]
         else if (cpu_box_go && cpu_one)
            o_msg_one_irq_flag <= 1'b0; // [R8]
         if (tgt_go && tgt_sel)
            o_msg_two_irq_flag <= 1'b1; // [R7]
         else if (cpu_box_go && cpu_two)
            o_msg_two_irq_flag <= 1'b0; // [R8]
      end
   end

   // answers: ack two cycles after request, retry one cycle after, from registers
   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         cpu_p1_reg     <= 1'b0;
         cpu_box_p1_reg <= 1'b0;
         cpu_lcs_p1_reg <= 32'h0000_0000;
         tgt_p1_reg     <= 1'b0;
         o_cpu_ack      <= 1'b0;
         o_cpu_retry    <= 1'b0;
         o_cpu_rdata    <= 32'h0000_0000;
         o_tgt_ack      <= 1'b0;
         o_tgt_retry    <= 1'b0;
         o_tgt_rdata    <= 32'h0000_0000;
      end else begin
         cpu_p1_reg     <= cpu_go;
         cpu_box_p1_reg <= cpu_box_go;
         cpu_lcs_p1_reg <= lcs_view; // [R17]
         tgt_p1_reg     <= tgt_go;
         o_cpu_ack      <= cpu_p1_reg;
         o_cpu_retry    <= cpu_ref; // [R15]
         if (cpu_p1_reg)
            o_cpu_rdata <= cpu_box_p1_reg ? mem_rdata : cpu_lcs_p1_reg;
         o_tgt_ack      <= tgt_p1_reg;
         o_tgt_retry    <= tgt_ref; // [R15]
         if (tgt_p1_reg)
            o_tgt_rdata <= mem_rdata; // [R1]
      end
   end

   // master side and pins
   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_lock_n         <= 1'b1;
         o_lock_n_oe      <= 1'b0;
         o_mst_use_lock   <= 1'b0;
         o_mst_permit     <= 1'b1;
         o_mst_reissue    <= 1'b0;
         o_tgt_lock_state <= 1'b0;
         o_refresh_grant  <= 1'b0;
      end else begin
         // lock pin held low through the whole locked sequence
         o_lock_n       <= m_state_next != M_LOCK; // [R9]
         o_lock_n_oe    <= m_state_next == M_LOCK; // [R10]
         o_mst_use_lock <= lock_req_reg &&
                           (lock_n_reg || m_state_reg == M_LOCK); // [R9]
         o_mst_permit   <= m_state_reg != M_LOCK ||
                           i_mst_addr == lock_tgt_reg; // [R11]
         o_mst_reissue  <= m_state_reg == M_LOCK && i_mst_retry &&
                           !(retry_cnt_reg + 8'h01 >= i_retry_limit); // [R12]
         o_tgt_lock_state <= t_state_next == T_LOCKED;
         // refresh does not look at the lock at all
         o_refresh_grant  <= i_refresh_req; // [R16]
      end
   end

endmodule // pmb_top

//--- tb/pmb_top_monitor.sv
/* port assertions for the message box and bus lock block.
   assumes one clock, active-low async reset, bound into pmb_top. */
`include "pmb_map.vh"
module pmb_mon (
   // clock, reset, cpu port
   input logic        i_clk,
   input logic        i_nrst,
   input logic        i_cpu_req,
   input logic [7:0]  i_cpu_addr,
   input logic        o_cpu_ack,
   input logic        o_cpu_retry,
   input logic [31:0] o_cpu_rdata,
   // pci side
   input logic        i_mem_space_enable_bit,
   input logic [31:0] i_mbox_base,
   input logic        i_tgt_req,
   input logic [3:0]  i_tgt_cmd,
   input logic [31:0] i_tgt_addr,
   input logic        o_tgt_ack,
   input logic        o_tgt_retry,
   input logic        o_tgt_lock_state,
   input logic        i_mst_start,
   input logic        i_mst_abort,
   input logic        o_mst_use_lock,
   input logic        o_lock_n_oe,
   input logic        o_msg_one_irq_flag,
   input logic        i_refresh_req,
   input logic        o_refresh_grant
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   wire mem_cmd = i_tgt_cmd inside {4'h6, 4'h7, 4'hc, 4'he, 4'hf};
   wire base_ok = i_tgt_addr[31:12] == i_mbox_base[31:12];
   wire hit_one = i_tgt_req && i_mem_space_enable_bit && mem_cmd && base_ok
                  && !i_tgt_addr[11] && !o_tgt_lock_state;
   a_cpu_ack_lat: assert property (o_cpu_ack |-> $past(i_cpu_req, 2) &&
      $past(i_cpu_addr, 2) inside {8'h30, 8'h34, 8'h60})
      else $error("cpu ack without mapped request");
   a_lcs_hi_zero: assert property (o_cpu_ack &&
      $past(i_cpu_addr, 2) == `PMB_OFF_LOCK_CS |-> o_cpu_rdata[31:4] == 0)
      else $error("lock register upper bits not zero");
   a_io_ignored: assert property (i_tgt_req && !mem_cmd |=>
      !o_tgt_retry ##1 !o_tgt_ack) else $error("non-memory cycle answered");
   a_mem_off_quiet: assert property (i_tgt_req && !i_mem_space_enable_bit
      |=> !o_tgt_retry ##1 !o_tgt_ack) else $error("answered while disabled");
   a_flag_set: assert property (hit_one |=> o_msg_one_irq_flag)
      else $error("box one flag not set");
   a_flag_clear: assert property (i_cpu_req && !i_tgt_req &&
      i_cpu_addr == `PMB_OFF_MSG_ONE && !o_tgt_lock_state
      |=> !o_msg_one_irq_flag) else $error("box one flag not cleared");
   a_lock_refuse: assert property (o_tgt_lock_state && i_cpu_req &&
      i_cpu_addr == `PMB_OFF_LOCK_CS |=> o_cpu_retry)
      else $error("cpu served while target locked");
   a_refresh_run: assert property (i_refresh_req |=> o_refresh_grant)
      else $error("refresh not granted");
   a_lock_start: assert property ($rose(o_lock_n_oe) |->
      ($past(i_mst_start) || $past(i_mst_start, 2)) && $past(o_mst_use_lock))
      else $error("lock driven without locked start");
   a_abort_end: assert property (o_lock_n_oe && i_mst_abort |=>
      !o_lock_n_oe) else $error("lock held after abort");
   c_tgt_lock: cover property ($rose(o_tgt_lock_state));
   c_cpu_retry: cover property (o_cpu_retry);
   c_mst_lock: cover property ($rose(o_lock_n_oe));
endmodule // pmb_mon

bind pmb_top pmb_mon mon_u (.i_clk, .i_nrst, .i_cpu_req, .i_cpu_addr,
   .o_cpu_ack, .o_cpu_retry, .o_cpu_rdata, .i_mem_space_enable_bit,
   .i_mbox_base, .i_tgt_req, .i_tgt_cmd, .i_tgt_addr, .o_tgt_ack,
   .o_tgt_retry, .o_tgt_lock_state, .i_mst_start, .i_mst_abort,
   .o_mst_use_lock, .o_lock_n_oe, .o_msg_one_irq_flag, .i_refresh_req,
   .o_refresh_grant);

//--- tb/pmb_pci_peer.sv
/* far-side pci agent: locking master pins and a target answering
   master accesses. assumes pulses are sampled on rising i_clk. */
module pmb_pci_peer (
   input  wire logic       i_clk,
   input  wire logic [1:0] i_mode,
   input  wire logic [3:0] i_delay,
   input  wire logic       i_hold,
   input  wire logic       i_start,
   output logic            o_frame_n,
   output logic            o_lock_n,
   output logic            o_done,
   output logic            o_retry,
   output logic            o_abort
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] cnt_reg = 4'h0;
   // released pins are driven back high by the model
   assign o_frame_n = !i_hold;
   assign o_lock_n = !i_hold;
   always @(posedge i_clk) begin
      if (i_start)
         cnt_reg <= i_delay;
      else if (cnt_reg != 4'h0)
         cnt_reg <= cnt_reg - 4'h1;
   end
   // slow targets answer late through i_delay
   assign o_done = cnt_reg == 4'h1 && i_mode == 2'h0;
   assign o_retry = cnt_reg == 4'h1 && i_mode == 2'h1;
   assign o_abort = cnt_reg == 4'h1 && i_mode == 2'h2;
endmodule // pmb_pci_peer

//--- tb/tb.sv
/* self-checking bench for pmb_top with a pci peer model.
   assumes the design hands back answers within three cycles. */
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_clk = 0, i_nrst = 0, i_cpu_req = 0, i_cpu_wr = 0, i_tgt_req = 0;
   logic i_mem_space_enable_bit = 0, i_tgt_locked = 0, i_tgt_lock_owner = 0;
   logic i_mst_start = 0, i_refresh_req = 0, hold = 0;
   logic [7:0] i_cpu_addr = 0, i_retry_limit = 8'h01;
   logic [31:0] i_cpu_wdata = 0, i_mbox_base = 0, i_tgt_addr = 0, rd;
   logic [31:0] i_tgt_wdata = 0, i_mst_addr = 0;
   logic [3:0] i_tgt_cmd = 0, delay = 4'h2;
   logic [1:0] mode = 0, st;
   wire i_frame_n, i_lock_n, i_mst_done, i_mst_retry, i_mst_abort;
   wire o_cpu_ack, o_cpu_retry, o_tgt_ack, o_tgt_retry, o_tgt_lock_state;
   wire o_lock_n, o_lock_n_oe, o_mst_use_lock, o_mst_permit, o_mst_reissue;
   wire o_msg_one_irq_flag, o_msg_two_irq_flag, o_refresh_grant;
   wire [31:0] o_cpu_rdata, o_tgt_rdata;
   int bad_count = 0, checked = 0;
   pmb_top dut_u (.i_clk, .i_nrst, .i_cpu_req, .i_cpu_wr, .i_cpu_addr,
      .i_cpu_wdata, .o_cpu_ack, .o_cpu_retry, .o_cpu_rdata,
      .i_mem_space_enable_bit, .i_mbox_base, .i_tgt_req, .i_tgt_cmd,
      .i_tgt_addr, .i_tgt_wdata, .i_tgt_locked, .i_tgt_lock_owner,
      .o_tgt_ack, .o_tgt_retry, .o_tgt_rdata, .o_tgt_lock_state,
      .i_frame_n, .i_lock_n, .o_lock_n, .o_lock_n_oe, .i_mst_start,
      .i_mst_addr, .i_mst_done, .i_mst_retry, .i_mst_abort,
      .i_retry_limit, .o_mst_use_lock, .o_mst_permit, .o_mst_reissue,
      .o_msg_one_irq_flag, .o_msg_two_irq_flag, .i_refresh_req,
      .o_refresh_grant);
   pmb_pci_peer peer_u (.i_clk(i_clk), .i_mode(mode), .i_delay(delay),
      .i_hold(hold), .i_start(i_mst_start), .o_frame_n(i_frame_n),
      .o_lock_n(i_lock_n), .o_done(i_mst_done), .o_retry(i_mst_retry),
      .o_abort(i_mst_abort));
   always #50 i_clk = ~i_clk;
   task stop_test;
      if (bad_count == 0 && checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask
   // one access on cpu (p=0, c[0]=write) or pci target (p=1, c=command)
   task acc(input logic p, input logic [3:0] c, input logic [31:0] a, d);
      @(negedge i_clk);
      if (p) begin
         i_tgt_req = 1;
         i_tgt_cmd = c;
         i_tgt_addr = a;
         i_tgt_wdata = d;
      end else begin
         i_cpu_req = 1;
         i_cpu_wr = c[0];
         i_cpu_addr = a[7:0];
         i_cpu_wdata = d;
      end
      @(negedge i_clk);
      i_tgt_req = 0;
      i_cpu_req = 0;
      st = 0;
      for (int k = 0; k < 3 && st == 0; k++) begin
         if ((p ? o_tgt_retry : o_cpu_retry) === 1'b1)
            st = 2;
         else if ((p ? o_tgt_ack : o_cpu_ack) === 1'b1)
            st = 1;
         else
            @(negedge i_clk);
      end
      rd = p ? o_tgt_rdata : o_cpu_rdata;
   endtask
   task cr(input logic [7:0] a, input logic [31:0] e);
      acc(0, 4'h0, a, 0);
      check(st, 1);
      check(rd, e);
   endtask
   task cw(input logic [7:0] a, input logic [31:0] d);
      acc(0, 4'h1, a, d);
      check(st, 1);
   endtask
   task mst(input logic [1:0] m, input logic [3:0] dl);
      mode = m;
      delay = dl;
      @(negedge i_clk);
      i_mst_start = 1;
      @(negedge i_clk);
      i_mst_start = 0;
   endtask
   task s_reset;
      cr(8'h30, 0);
      cr(8'h34, 0);
      cr(8'h60, 0);
   endtask
   task s_boxes;
      acc(1, 4'h7, 32'h800, 32'h5);
      check(st, 0);
      i_mem_space_enable_bit = 1;
      acc(1, 4'h7, 32'h800, 32'h0000_abcd);
      check(o_msg_two_irq_flag, 1);
      cr(8'h34, 32'h0000_abcd);
      check(o_msg_two_irq_flag, 0);
      i_mbox_base = 32'h0004_0000;
      cw(8'h30, 32'h1234_5678);
      acc(1, 4'h2, 32'h0004_0000, 0);
      check({st, o_msg_one_irq_flag}, 0);
      acc(1, 4'hb, 32'h0004_0000, 32'h1);
      check(st, 0);
      acc(1, 4'h6, 32'h0004_0000, 0);
      check(rd, 32'h1234_5678);
      check(o_msg_one_irq_flag, 1);
      acc(1, 4'hf, 32'h0004_0800, 32'h9);
      acc(1, 4'he, 32'h0004_0800, 0);
      check(rd, 32'h9);
      check(o_msg_two_irq_flag, 1);
      acc(1, 4'hc, 32'h0004_0000, 0);
      check(rd, 32'h1234_5678);
      cw(8'h30, 32'h0);
      check(o_msg_one_irq_flag, 0);
   endtask
   task s_master;
      i_retry_limit = 8'h02;
      cw(8'h60, 32'hffff_fff1);
      cr(8'h60, 32'h1);
      check(o_mst_use_lock, 1);
      mst(2'h1, 4'h2);
      repeat (2) @(negedge i_clk);
      check(o_mst_reissue, 1);
      mst(2'h1, 4'h2);
      repeat (2) @(negedge i_clk);
      check(o_mst_reissue, 0);
      repeat (2) @(negedge i_clk);
      check({o_lock_n, o_lock_n_oe}, 2'b01);
      cr(8'h60, 32'h5);
      cw(8'h60, 32'h1);
      cr(8'h60, 32'h1);
      i_mst_addr = 32'h10;
      repeat (2) @(negedge i_clk);
      check(o_mst_permit, 0);
      i_mst_addr = 32'h0;
      repeat (2) @(negedge i_clk);
      check(o_mst_permit, 1);
      mst(2'h2, 4'h2);
      repeat (4) @(negedge i_clk);
      check(o_lock_n_oe, 0);
      cr(8'h60, 32'h9);
      cw(8'h60, 32'h1);
      mst(2'h0, 4'hc);
      cw(8'h60, 32'h0);
      check(o_lock_n_oe, 1);
      repeat (12) @(negedge i_clk);
      check({o_lock_n, o_lock_n_oe}, 2'b10);
   endtask
   task s_target;
      i_tgt_locked = 1;
      i_tgt_lock_owner = 1;
      hold = 1;
      acc(1, 4'h7, 32'h0004_0000, 32'h77);
      check(o_tgt_lock_state, 1);
      i_tgt_locked = 0;
      i_tgt_lock_owner = 0;
      acc(1, 4'h6, 32'h0004_0000, 0);
      check(st, 2);
      acc(0, 4'h0, 32'h60, 0);
      check(st, 2);
      i_refresh_req = 1;
      @(negedge i_clk);
      check(o_refresh_grant, 1);
      i_refresh_req = 0;
      hold = 0;
      repeat (5) @(negedge i_clk);
      check(o_tgt_lock_state, 0);
      cw(8'h60, 32'h2);
      i_tgt_locked = 1;
      i_tgt_lock_owner = 1;
      hold = 1;
      acc(1, 4'h6, 32'h0004_0000, 0);
      check(o_tgt_lock_state, 0);
      hold = 0;
   endtask
   initial begin
      #2000000;
      bad_count++;
      stop_test;
   end
   initial begin
      repeat (20) @(negedge i_clk);
      i_nrst = 1;
      s_reset;
      s_boxes;
      s_master;
      s_target;
      stop_test;
   end
endmodule // tb
